// file: design/access_burst_framer.sv
// Uplink random-access burst framer: access-slot timing, preambles, message.
// Assumes a frame-boundary pulse from the broadcast receiver and synchronous inputs.
//
// Function
// - Normal mode starts only at access slots, 1.25 ms apart
// - Normal mode uses only slots announced on broadcast channel
// - Preambles of 1 ms, then 10 ms message
// - Signature of 16 symbols, each +-(1+j)
// - Spread each symbol with 256-chip real code
// - Sixteen signatures from length-16 orthogonal set
// - Data and control parts sent in parallel
// - Data spreading factor 256, 128, 64, 32 only
// - Control carries pilot and rate, factor 256
// - Rate information names data spreading factor
// - Data carries access request or user packet
// - Fast mode sends signature 8, same code
// - Fast mode starts at assigned 16-chip slot
// - Fast transmission is preamble only
// - Control follows 16 slots of 0.625 ms
`timescale 1ns/1ps

module access_burst_framer
  import access_burst_pkg::*;
#(
  parameter int P_ACCESS_SLOT_CHIPS = ACCESS_SLOT_CHIPS,  // Access slot length in chips
  parameter int P_MESSAGE_CHIPS     = MESSAGE_CHIPS       // Message and frame length in chips
) (
  input  wire logic        i_mclk,         // System clock, 100 MHz
  input  wire logic        i_rstn,         // Asynchronous reset, active low
  input  wire logic        i_frame_start,  // Broadcast frame boundary pulse
  input  wire logic [7:0]  i_slot_avail,   // Announced access slots, one bit each
  input  wire logic        i_start,        // Request a burst
  input  wire access_req_s i_req,          // Burst settings, taken with i_start
  input  wire logic        i_acq,          // Acquisition indication pulse
  input  wire logic        i_data_bit,     // Current message data bit
  output logic             o_data_req,     // Pulse: data bit was taken
  output tx_chip_s         o_tx,           // Chip output
  output logic             o_busy,         // Burst in progress
  output logic             o_done          // Pulse: burst finished
);

  ////////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    phase_e            phase;      // Burst phase
    logic [CHIP_ACC_W-1:0] acc;    // Fractional chip divider
    logic [15:0]       frame_pos;  // Chip position in the broadcast frame
    logic [12:0]       slot_pos;   // Chip position in the access slot
    logic [2:0]        slot_idx;   // Current access slot index
    logic [15:0]       cnt;        // Chip counter inside preamble or message
    logic [11:0]       cpos;       // Chip position inside control slot
    access_req_s       req;        // Latched settings
    logic              acq;        // Acquisition seen during this preamble
    logic              dbit;       // Held data bit
    tx_chip_s          tx;         // Registered chip output
    logic              data_req;   // Data bit taken
    logic              done;       // Burst finished
  } state_s;

  state_s      s;                  // Current state
  state_s      next_s;             // Next state
  logic [1:0]  rst_sync;           // Reset release synchroniser
  logic        rstn;               // Synchronised reset

  ////////////////////////////////////////////////////////////////////////////////
  // Orthogonal code chip: parity of index and position
  function automatic logic code_chip(input logic [7:0] idx, input logic [7:0] pos);
    return ^(idx & pos);
  endfunction

  // Preamble chip: signature symbol times spreading code
  function automatic logic pre_chip(input logic [3:0] sig, input logic [11:0] c);
    return code_chip({4'h0, sig}, {4'h0, c[11:8]}) ^ code_chip(PRE_CODE_IDX, c[7:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rstn = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic                  chip_en;  // One-cycle chip-rate enable
    logic [CHIP_ACC_W:0]   acc_sum;  // Divider sum
    logic                  go;       // Burst preamble starts this chip
    logic [15:0]           c;        // Chip index being sent
    logic [7:0]            sf_mask;  // Chip mask of the data spreading factor
    logic                  cbit;     // Control bit of this chip
    logic [3:0]            sig;      // Signature in use
    chip_en = 1'b0;
    acc_sum = '0;
    go      = 1'b0;
    c       = s.cnt;
    sf_mask = SF_MAX_MASK >> s.req.sf_sel;
    cbit    = 1'b0;
    sig     = s.req.fast ? FAST_SIG_IDX : s.req.sig_idx;
    next_s  = s;
    next_s.tx       = '0;
    next_s.data_req = 1'b0;
    next_s.done     = 1'b0;

    // Chip-rate enable from fractional divider
    acc_sum = {1'b0, s.acc} + (CHIP_ACC_W+1)'(CHIP_KHZ);
    if (acc_sum >= (CHIP_ACC_W+1)'(CLK_KHZ)) begin
      chip_en     = 1'b1;
      next_s.acc  = CHIP_ACC_W'(acc_sum - (CHIP_ACC_W+1)'(CLK_KHZ));
    end else begin
      next_s.acc  = CHIP_ACC_W'(acc_sum);
    end

    // Frame and access-slot position; boundary makes the next chip position 0
    if (i_frame_start) begin
      next_s.frame_pos = 16'(P_MESSAGE_CHIPS - 1);
      next_s.slot_pos  = 13'(P_ACCESS_SLOT_CHIPS - 1);
      next_s.slot_idx  = 3'(NUM_ACCESS_SLOTS - 1);
    end else if (chip_en) begin
      // Frame position wraps once per 10 ms
      if (s.frame_pos == 16'(P_MESSAGE_CHIPS - 1)) begin
        next_s.frame_pos = '0;
      end else begin
        next_s.frame_pos = s.frame_pos + 16'h1;
      end
      // Access slots step every 1.25 ms
      if (s.slot_pos == 13'(P_ACCESS_SLOT_CHIPS - 1)) begin
        next_s.slot_pos = '0;
        next_s.slot_idx = s.slot_idx + 3'h1;
      end else begin
        next_s.slot_pos = s.slot_pos + 13'h1;
      end
    end

    case (s.phase)
      // Take a request
      ST_IDLE: begin
        if (i_start) begin
          next_s.req   = i_req;
          next_s.phase = ST_WAIT_SLOT;
        end
      end
      // Wait for an allowed start chip
      ST_WAIT_SLOT: begin
        if (chip_en && !i_frame_start) begin
          if (s.req.fast) begin
            // Assigned fast access slot, 16 chips apart
            go = (next_s.frame_pos == 16'(int'(s.req.fast_slot) * FAST_SLOT_CHIPS));
          end else begin
            // Access slot start that the cell announced
            go = (next_s.slot_pos == '0) && i_slot_avail[next_s.slot_idx];
          end
        end
        if (go) begin
          next_s.phase = ST_PREAMBLE;
          next_s.acq   = i_acq;
          c            = '0;
        end
      end
      ST_PREAMBLE: begin
        // Acquisition latches; a pulse on the clear chip is kept
        next_s.acq = s.acq | i_acq;
      end
      default: begin
      end
    endcase

    // Preamble chips, I and Q equal for +-(1+j)
    if ((s.phase == ST_PREAMBLE && chip_en) || go) begin
      next_s.tx.valid = 1'b1;
      next_s.tx.i     = pre_chip(sig, c[11:0]);
      next_s.tx.q     = pre_chip(sig, c[11:0]);
      next_s.cnt      = c + 16'h1;
      if (c == 16'(PREAMBLE_CHIPS - 1)) begin
        next_s.cnt  = '0;
        next_s.cpos = '0;
        if (s.req.fast) begin
          next_s.phase = ST_IDLE;
          next_s.done  = 1'b1;
        end else if (next_s.acq) begin
          next_s.phase = ST_MESSAGE;
        end else begin
          next_s.phase = ST_WAIT_SLOT;
        end
      end
    end

    // Message chips: data on I, control on Q
    if (s.phase == ST_MESSAGE && chip_en) begin
      next_s.tx.valid = 1'b1;
      // Data bit taken at each data symbol boundary
      if ((s.cnt[7:0] & sf_mask) == 8'h00) begin
        next_s.dbit     = i_data_bit;
        next_s.data_req = 1'b1;
        next_s.tx.i     = i_data_bit ^ code_chip(DATA_CODE_IDX, 8'h00);
      end else begin
        next_s.tx.i = s.dbit ^ code_chip(DATA_CODE_IDX & sf_mask,
                                         s.cnt[7:0] & sf_mask);
      end
      // Control slot: pilot bits, then two rate bits
      if (s.cpos[11:8] < PILOT_BITS) begin
        cbit = 1'b1;
      end else if (s.cpos[11:8] == PILOT_BITS) begin
        cbit = s.req.sf_sel[1];
      end else begin
        cbit = s.req.sf_sel[0];
      end
      next_s.tx.q = cbit ^ code_chip(CTRL_CODE_IDX, s.cpos[7:0]);
      if (s.cpos == 12'(CTRL_SLOT_CHIPS - 1)) begin
        next_s.cpos = '0;
      end else begin
        next_s.cpos = s.cpos + 12'h1;
      end
      next_s.cnt = s.cnt + 16'h1;
      if (s.cnt == 16'(P_MESSAGE_CHIPS - 1)) begin
        next_s.phase = ST_IDLE;
        next_s.done  = 1'b1;
        next_s.cnt   = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_tx       = s.tx;
  assign o_data_req = s.data_req;
  assign o_done     = s.done;
  assign o_busy     = (s.phase != ST_IDLE);

endmodule

// file: design/access_burst_pkg.sv
// Constants, types and timing for the uplink random-access burst framer.
// Assumes a 100 MHz system clock; the chip rate is derived from it by a divider.
package access_burst_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and chip rate
  localparam int CLK_KHZ        = 100000;  // System clock rate
  localparam int CHIP_KHZ       = 4096;    // Chip rate
  localparam int CHIP_ACC_W     = 17;      // Width of the fractional chip divider

  ////////////////////////////////////////////////////////////////////////////////
  // Times as printed, and chip counts derived from them
  localparam int ACCESS_SLOT_US = 1250;    // Spacing of access slots
  localparam int PREAMBLE_US    = 1000;    // Length of one preamble
  localparam int MESSAGE_US     = 10000;   // Length of the message, also one frame
  localparam int CTRL_SLOT_US   = 625;     // Control-part slot
  localparam int ACCESS_SLOT_CHIPS = ACCESS_SLOT_US * CHIP_KHZ / 1000;  // 5120
  localparam int PREAMBLE_CHIPS    = PREAMBLE_US * CHIP_KHZ / 1000;     // 4096
  localparam int MESSAGE_CHIPS     = MESSAGE_US * CHIP_KHZ / 1000;      // 40960
  localparam int CTRL_SLOT_CHIPS   = CTRL_SLOT_US * CHIP_KHZ / 1000;    // 2560
  localparam int NUM_ACCESS_SLOTS  = MESSAGE_US / ACCESS_SLOT_US;       // 8
  localparam int FAST_SLOT_CHIPS   = 16;   // Spacing of fast access slots

  ////////////////////////////////////////////////////////////////////////////////
  // Codes and fields
  localparam int           SIG_SYMBOLS   = 16;      // Symbols per signature
  localparam int           SYM_CHIPS     = 256;     // Preamble code length
  localparam logic [3:0]   FAST_SIG_IDX  = 4'h8;    // Signature used in fast mode
  localparam logic [7:0]   PRE_CODE_IDX  = 8'h5a;   // Preamble spreading code index
  localparam logic [7:0]   DATA_CODE_IDX = 8'h01;   // Data channelization index (< 32)
  localparam logic [7:0]   CTRL_CODE_IDX = 8'h00;   // Control channelization index
  localparam logic [3:0]   PILOT_BITS    = 4'h8;    // Pilot bits leading each slot
  localparam logic [7:0]   SF_MAX_MASK   = 8'hff;   // Chip mask for spreading factor 256

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    ST_IDLE, ST_WAIT_SLOT, ST_PREAMBLE, ST_MESSAGE
  } phase_e;

  typedef struct packed {
    logic        fast;       // Fast-signalling transmission
    logic [3:0]  sig_idx;    // Preamble signature for normal access
    logic [1:0]  sf_sel;     // Data spreading factor 256 >> sf_sel
    logic [11:0] fast_slot;  // Assigned fast access slot index
  } access_req_s;

  typedef struct packed {
    logic valid;             // One chip presented this cycle
    logic i;                 // In-phase chip, 0 = +1, 1 = -1
    logic q;                 // Quadrature chip, 0 = +1, 1 = -1
  } tx_chip_s;

endpackage

// file: verif/access_burst_chk.sv
// Checker for the burst framer: chip pacing, burst length, idle behaviour.
// Assumes it is bound to the framer and sees only its ports.
`timescale 1ns/1ps
module access_burst_chk
  import access_burst_pkg::*;
(
  input wire logic     i_mclk,      // Clock
  input wire logic     i_rstn,      // Reset, active low
  input wire logic     i_start,     // Burst request
  input wire logic     o_data_req,  // Data bit taken
  input wire tx_chip_s o_tx,        // Chip output
  input wire logic     o_busy,      // Burst in progress
  input wire logic     o_done       // Burst finished
);
  ////////////////////////////////////////
  logic [11:0] cnt;         // Chips of this burst, modulo one preamble
  logic        first_done;  // First preamble complete

  // Count chips while a burst runs
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt        <= '0;
      first_done <= 1'b0;
    end else if (!o_busy) begin
      cnt        <= '0;
      first_done <= 1'b0;
    end else if (o_tx.valid) begin
      cnt        <= cnt + 12'h001;
      first_done <= first_done | (cnt == 12'hfff);
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  chk_valid_busy: assert property (o_tx.valid |-> (o_busy ^ o_done))
    else $error("chip outside a burst");
  chk_start_busy: assert property (i_start && !o_busy |=> o_busy)
    else $error("request not taken");
  chk_chip_gap: assert property (o_tx.valid |=> !o_tx.valid [*8])
    else $error("chips too close");
  chk_chip_pace: assert property (o_tx.valid && cnt != 12'hfff |-> ##[24:25] o_tx.valid)
    else $error("preamble chip missing");
  chk_pre_iq: assert property (o_tx.valid && !first_done |-> o_tx.i == o_tx.q)
    else $error("preamble i and q differ");
  chk_done_chip: assert property (o_done |-> o_tx.valid && cnt == 12'hfff)
    else $error("done not on last chip");
  chk_done_idle: assert property (o_done |=> !o_busy && !o_tx.valid)
    else $error("burst goes on after done");
  chk_busy_end: assert property ($fell(o_busy) |-> o_done)
    else $error("burst ended without done");
  chk_req_msg: assert property (o_data_req |-> o_busy && first_done)
    else $error("data taken before message");
endmodule

bind access_burst_framer access_burst_chk i_chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(i_start), .o_data_req(o_data_req),
  .o_tx(o_tx), .o_busy(o_busy), .o_done(o_done));

// file: verif/cell_network_model.sv
// Cell side model: frame boundary and announced slots for the framer.
// Assumes the bench asks for each boundary; it never acquires a preamble.
`timescale 1ns/1ps
module cell_network_model (
  input  wire logic       i_mclk,         // Clock
  input  wire logic       i_frame_go,     // Bench asks for a boundary
  input  wire logic [7:0] i_mask,         // Slots the cell offers
  output logic            o_frame_start,  // Boundary pulse
  output logic [7:0]      o_slot_avail,   // Announced slots
  output logic            o_acq           // Acquisition indication
);
  // One station only, so each fast slot has one owner
  always_ff @(posedge i_mclk) begin
    o_frame_start <= i_frame_go;  // One-cycle marker
    o_slot_avail  <= i_mask;
    o_acq         <= 1'b0;        // No acquisition
  end
endmodule

// file: verif/random_access_burst_framer_tb_top.sv
// Bench for the burst framer: slot timing, preamble chips, refusal, fast burst.
// Assumes package, framer, checker and cell model are compiled first.
`timescale 1ns/1ps
module random_access_burst_framer_tb_top;
  import access_burst_pkg::*;
  logic        i_mclk;       // Clock
  logic        i_rstn;       // Reset, active low
  logic        i_start;      // Burst request
  access_req_s i_req;        // Burst settings
  logic        data_bit;     // Message data bit to the framer
  logic        frame_go;     // Boundary request to model
  logic [7:0]  mask;         // Slots the cell offers
  logic        frame_start;  // Boundary pulse
  logic [7:0]  slot_avail;   // Announced slots
  logic        acq;          // Acquisition indication
  logic        o_data_req;   // Data bit taken
  tx_chip_s    o_tx;         // Chip output
  logic        o_busy;       // Burst in progress
  logic        o_done;       // Burst finished
  int          fails;        // Mismatches
  int          num_checks;   // Comparisons

  // Short access slots keep the wait for slot 1 brief
  access_burst_framer #(.P_ACCESS_SLOT_CHIPS(16), .P_MESSAGE_CHIPS(8192)) i_dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_frame_start(frame_start),
    .i_slot_avail(slot_avail), .i_start(i_start), .i_req(i_req), .i_acq(acq),
    .i_data_bit(data_bit), .o_data_req(o_data_req), .o_tx(o_tx), .o_busy(o_busy),
    .o_done(o_done));
  cell_network_model i_cell (.i_mclk(i_mclk), .i_frame_go(frame_go), .i_mask(mask),
    .o_frame_start(frame_start), .o_slot_avail(slot_avail), .o_acq(acq));

  ////////////////////////////////////////
  // Clock at 100 MHz
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Expected preamble chip: signature bit xor code bit
  function automatic logic exp_chip(input logic [3:0] sig, input logic [11:0] k);
    return ^(sig & k[11:8]) ^ ^(PRE_CODE_IDX & k[7:0]);
  endfunction

  // Bounded wait for the next chip
  task automatic wait_chip(input int lim, output int n);
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_tx.valid !== 1'b1 && n < lim);
    chk(n < lim, "chip wait");
    if (n >= lim) begin
      end_sim();
    end
  endtask

  task automatic do_reset();
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask

  task automatic pulse_frame();
    @(posedge i_mclk);
    frame_go <= 1'b1;
    @(posedge i_mclk);
    frame_go <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic send_req(input logic f, input logic [3:0] s, input logic [11:0] fs);
    @(posedge i_mclk);
    i_start <= 1'b1;
    i_req   <= '{fast: f, sig_idx: s, sf_sel: 2'h2, fast_slot: fs};
    @(posedge i_mclk);
    i_start <= 1'b0;
  endtask

  ////////////////////////////////////////
  // Normal burst in slot 1, refused request, reset mid-run
  task automatic sc_normal();
    int   n;
    logic e;
    mask <= 8'h02;
    pulse_frame();
    send_req(1'b0, 4'h3, 12'h000);
    @(negedge i_mclk);
    chk(o_busy === 1'b1, "busy after request");
    wait_chip(8000, n);
    chk(n > 385 && n < 420, "slot 1 start");
    for (int k = 0; k < 264; k++) begin
      if (k > 0) wait_chip(30, n);
      e = exp_chip(4'h3, 12'(k));
      chk(o_tx.i === e && o_tx.q === e, "preamble chip");
      chk(o_data_req === 1'b0, "data taken in preamble");
      if (k == 2) send_req(1'b0, 4'h6, 12'h000);
    end
    do_reset();
    @(negedge i_mclk);
    chk(o_busy === 1'b0 && o_tx.valid === 1'b0, "idle after reset");
  endtask

  // Fast burst in fast slot 2: signature 8, preamble only
  task automatic sc_fast();
    int   n;
    logic e;
    mask <= 8'h00;
    pulse_frame();
    send_req(1'b1, 4'h3, 12'h002);
    wait_chip(2000, n);
    chk(n > 750 && n < 815, "fast slot start");
    for (int k = 0; k < 4096; k++) begin
      if (k > 0) wait_chip(30, n);
      e = exp_chip(FAST_SIG_IDX, 12'(k));
      chk(o_tx.i === e && o_tx.q === e, "fast chip");
      chk(o_done === (k == 4095), "done marker");
      chk(o_data_req === 1'b0, "data taken in fast burst");
    end
    @(negedge i_mclk);
    chk(o_busy === 1'b0, "idle after fast burst");
    n = 0;
    repeat (300) begin
      @(negedge i_mclk);
      if (o_tx.valid === 1'b1 || o_data_req === 1'b1) n++;
    end
    chk(n == 0, "message after fast burst");
  endtask

  initial begin
    i_rstn   = 1'b0;
    i_start  = 1'b0;
    i_req    = '0;
    data_bit = 1'b1;
    frame_go = 1'b0;
    mask     = 8'h00;
    do_reset();
    sc_normal();
    sc_fast();
    end_sim();
  end
endmodule
